/* File: logic/wwd_regs.svh */
// register offsets, field positions, reset values and timing counts of the window watchdog
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH
// =====================================================================
// base windows and register offsets
`define WWD_BASE_BLOCKING    16'h0E00
`define WWD_BASE_NONBLOCKING 16'h0F00
`define WWD_BASE_MASK        16'hFF00
`define WWD_OFF_CONTROL      8'h10
`define WWD_OFF_STATUS       8'h12
`define WWD_OFF_REARM        8'h14
// =====================================================================
// field positions
`define WWD_TEST_MASK_BIT    15
`define WWD_TO_MASK_HI       10
`define WWD_TO_MASK_LO       8
`define WWD_TEST_BIT         7
`define WWD_TO_HI            2
`define WWD_TO_LO            0
`define WWD_ST_DISABLED      1
`define WWD_ST_WINDOW        0
// =====================================================================
// reset values and keys
`define WWD_TEST_RESET       1'h1
`define WWD_TO_RESET         3'h4
`define WWD_TO_OFF           3'h0
`define WWD_KEY_FIRST        8'hAA
`define WWD_KEY_SECOND       8'h55
// =====================================================================
// timing: oscillator tick period and timeout figures in ms
`define WWD_TICK_MS          1
`define WWD_INIT_TIMEOUT_MS  256
`endif

/* File: logic/wwd_pkg.sv */
// types shared by the window watchdog modules
package wwd_pkg;
	// watchdog operating phase
	typedef enum logic [1:0] {
		WWD_OFF,
		WWD_INITIAL,
		WWD_WINDOW
	} wwd_phase_t;
	typedef logic [11:0] wwd_ms_t;
endpackage : wwd_pkg

/* File: logic/wwd_tick_if.sv */
// tick and timeout link between the watchdog register block and its counter
`timescale 1ns/1ps
interface wwd_tick_if;
	import wwd_pkg::*;
	logic    restart;
	wwd_ms_t limit;
	logic    half_reached;
	logic    expired;
	modport ctl (output restart, output limit, input half_reached, input expired);
	modport cnt (input restart, input limit, output half_reached, output expired);
endinterface : wwd_tick_if

/* File: logic/wwd_ms_counter.sv */
// millisecond counter stepped by the oscillator tick, with half and full detection
`timescale 1ns/1ps
module wwd_ms_counter
	import wwd_pkg::*;
(
	input  wire logic CORE_CLK,
	input  wire logic RST,
	input  wire logic osc_ms_tick,
	wwd_tick_if.cnt   lnk
);
	wwd_ms_t count_reg;
	// =====================================================================
	// count only on oscillator ticks so the bus clock rate never sets timing
	always_ff @(posedge CORE_CLK) begin
		if (RST || lnk.restart) begin
			count_reg <= '0;
		end else if (osc_ms_tick && !lnk.expired) begin
			count_reg <= count_reg + 12'h001;
		end
	end
	assign lnk.half_reached = (count_reg >= {1'b0, lnk.limit[11:1]});
	assign lnk.expired      = (count_reg >= lnk.limit);
endmodule : wwd_ms_counter

/* File: logic/wwd_top.sv */
// window watchdog: control, status and rearm registers with window sequencing
`timescale 1ns/1ps
`include "wwd_regs.svh"
module wwd_top
	import wwd_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        OSC_MS_TICK,
	input  wire logic [15:0] ADDR,
	input  wire logic [15:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [15:0] RDATA,
	output logic             WD_RESET_REQ
);
	wwd_tick_if lnk ();

	wwd_phase_t  phase_reg;
	logic        test_bit_reg;
	logic [2:0]  timeout_select_reg;
	logic [7:0]  rearm_key_reg;
	logic        expect_aa_reg;
	logic        restart_pend_reg;
	logic [15:0] rdata_reg;
	logic        fault_reg;

	logic        base_hit;
	logic [7:0]  offset;
	logic        wr_ctl;
	logic        wr_rr;
	logic        disabled_flag;
	logic        window_open_flag;
	logic [7:0]  expected_key;
	logic        key_ok;
	logic        violation;

	// =====================================================================
	// address decode: both base windows reach the same registers
	assign base_hit = ((ADDR & `WWD_BASE_MASK) == `WWD_BASE_BLOCKING) ||
	                  ((ADDR & `WWD_BASE_MASK) == `WWD_BASE_NONBLOCKING);
	assign offset   = ADDR[7:0];
	assign wr_ctl   = WR && base_hit && (offset == `WWD_OFF_CONTROL);
	assign wr_rr    = WR && base_hit && (offset == `WWD_OFF_REARM);

	// =====================================================================
	// timeout decode into milliseconds
	function automatic wwd_ms_t timeout_ms(input logic [2:0] code);
		case (code)
			3'h1:    timeout_ms = 12'h004;
			3'h2:    timeout_ms = 12'h010;
			3'h3:    timeout_ms = 12'h040;
			3'h4:    timeout_ms = 12'h100;
			3'h5:    timeout_ms = 12'h200;
			3'h6:    timeout_ms = 12'h400;
			3'h7:    timeout_ms = 12'h800;
			default: timeout_ms = 12'h000; // code 000: off
		endcase
	endfunction : timeout_ms

	// =====================================================================
	// status flags
	assign disabled_flag    = (phase_reg == WWD_OFF);
	// the initial phase is always open; window phase opens at half time
	// the count is still stale while a restart is pending, so keep the window shut then
	assign window_open_flag = (phase_reg == WWD_INITIAL) ||
	                          ((phase_reg == WWD_WINDOW) && !restart_pend_reg &&
	                           lnk.half_reached);
	assign expected_key     = expect_aa_reg ? `WWD_KEY_FIRST : `WWD_KEY_SECOND;
	assign key_ok           = (WDATA[7:0] == expected_key);

	// =====================================================================
	// violation detection: closed-window rearm, wrong key, or expiry
	always_comb begin
		violation = 1'b0;
		if (!disabled_flag) begin
			if (wr_rr && !window_open_flag) begin
				violation = 1'b1;
			end else if (wr_rr && !key_ok) begin
				violation = 1'b1;
			end else if (lnk.expired && !restart_pend_reg) begin
				violation = 1'b1;
			end
		end
	end

	// =====================================================================
	// counter link: initial phase uses the fixed 256 ms limit
	assign lnk.restart = restart_pend_reg;
	assign lnk.limit   = (phase_reg == WWD_INITIAL) ? 12'(`WWD_INIT_TIMEOUT_MS)
	                                                 : timeout_ms(timeout_select_reg);

	wwd_ms_counter wwd_ms_counter_inst (
		.CORE_CLK    (CORE_CLK),
		.RST         (RST),
		.osc_ms_tick (OSC_MS_TICK),
		.lnk         (lnk)
	);

	// =====================================================================
	// control register: masked field updates
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			test_bit_reg       <= `WWD_TEST_RESET;
			timeout_select_reg <= `WWD_TO_RESET;
		end else if (wr_ctl) begin
			if (WDATA[`WWD_TEST_MASK_BIT]) begin
				test_bit_reg <= WDATA[`WWD_TEST_BIT];
			end
			if (|WDATA[`WWD_TO_MASK_HI:`WWD_TO_MASK_LO]) begin
				timeout_select_reg <= WDATA[`WWD_TO_HI:`WWD_TO_LO];
			end
		end
	end

	// =====================================================================
	// phase sequencing; test bit deliberately unused here
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			phase_reg        <= WWD_INITIAL;
			expect_aa_reg    <= 1'b1;
			restart_pend_reg <= 1'b1;
		end else begin
			restart_pend_reg <= 1'b0;
			case (phase_reg)
				WWD_OFF: begin
					// rearm writes are ignored while off
					if (wr_ctl && (|WDATA[`WWD_TO_MASK_HI:`WWD_TO_MASK_LO]) &&
					    (WDATA[`WWD_TO_HI:`WWD_TO_LO] != `WWD_TO_OFF)) begin
						phase_reg        <= WWD_WINDOW;
						restart_pend_reg <= 1'b1;
					end
				end
				WWD_INITIAL, WWD_WINDOW: begin
					if (violation) begin
						// start over as after power-up
						phase_reg        <= WWD_INITIAL;
						expect_aa_reg    <= 1'b1;
						restart_pend_reg <= 1'b1;
					end else if (wr_ctl && (|WDATA[`WWD_TO_MASK_HI:`WWD_TO_MASK_LO]) &&
					             (WDATA[`WWD_TO_HI:`WWD_TO_LO] == `WWD_TO_OFF)) begin
						phase_reg <= WWD_OFF;
					end else if (wr_rr) begin
						phase_reg        <= WWD_WINDOW;
						expect_aa_reg    <= !expect_aa_reg;
						restart_pend_reg <= 1'b1;
					end
				end
				default: begin
					phase_reg <= WWD_INITIAL;
				end
			endcase
		end
	end

	// =====================================================================
	// rearm register keeps the last write made while enabled, rejected keys included, for read-back
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rearm_key_reg <= 8'h00;
		end else if (wr_rr && !disabled_flag) begin
			rearm_key_reg <= WDATA[7:0];
		end
	end

	// =====================================================================
	// reset request: registered one-cycle pulse
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= violation;
		end
	end
	assign WD_RESET_REQ = fault_reg;

	// =====================================================================
	// read data, valid the cycle after the strobe only
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_reg <= 16'h0000;
		end else if (RD && base_hit) begin
			case (offset)
				`WWD_OFF_CONTROL: rdata_reg <= {8'h00, test_bit_reg, 4'h0, timeout_select_reg};
				`WWD_OFF_STATUS:  rdata_reg <= {14'h0000, disabled_flag, window_open_flag};
				`WWD_OFF_REARM:   rdata_reg <= {8'h00, rearm_key_reg};
				default:          rdata_reg <= 16'h0000; // unmapped reads zero
			endcase
		end else begin
			rdata_reg <= 16'h0000;
		end
	end
	assign RDATA = rdata_reg;
endmodule : wwd_top

/* File: tb/wwd_top_props.sv */
// assertions on the window watchdog register port
`timescale 1ns/1ps
module wwd_top_props (
	input wire logic        CORE_CLK,
	input wire logic        RST,
	input wire logic        OSC_MS_TICK,
	input wire logic [15:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [15:0] RDATA,
	input wire logic        WD_RESET_REQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	// =========================================================
	// shadow of control fields, rebuilt from bus writes
	logic       tst_reg;
	logic [2:0] to_reg;
	wire        sel = ADDR[15:9] == 7'h07;
	wire        cw  = WR && sel && ADDR[7:0] == 8'h10;
	wire        kw  = WR && sel && ADDR[7:0] == 8'h14;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tst_reg <= 1'h1;
			to_reg  <= 3'h4;
		end else if (cw) begin
			tst_reg <= WDATA[15] ? WDATA[7] : tst_reg;
			to_reg  <= (WDATA[10:8] != 3'h0) ? WDATA[2:0] : to_reg;
		end
	end
	sequence s_ctl_rd;
		RD && sel && ADDR[7:0] == 8'h10;
	endsequence
	sequence s_st_rd;
		RD && sel && ADDR[7:0] == 8'h12;
	endsequence
	// =========================================================
	// read path and reset request
	property p_ctl;
		s_ctl_rd |=> RDATA == {8'h00, $past(tst_reg), 4'h0, $past(to_reg)};
	endproperty
	a_ctl: assert property (p_ctl) else $error("control readback wrong");
	property p_st;
		s_st_rd |=> RDATA[15:1] == {14'h0000, $past(to_reg) == 3'h0};
	endproperty
	a_st: assert property (p_st) else $error("disabled flag wrong");
	property p_idle;
		!$past(RD) |-> RDATA == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer cycle");
	property p_unsel;
		RD && !sel |=> RDATA == 16'h0000;
	endproperty
	a_unsel: assert property (p_unsel) else $error("address outside base windows answered");
	property p_rsvd;
		RD && sel && ADDR[7:0] == 8'h16 |=> RDATA == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved offset not zero");
	property p_pulse;
		WD_RESET_REQ |=> !WD_RESET_REQ;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset request longer than one cycle");
	property p_badkey;
		kw && WDATA[7:0] != 8'hAA && WDATA[7:0] != 8'h55 && to_reg != 3'h0 |=> WD_RESET_REQ;
	endproperty
	a_badkey: assert property (p_badkey) else $error("wrong key gave no reset");
	property p_quiet;
		to_reg == 3'h0 && $past(to_reg) == 3'h0 |-> !WD_RESET_REQ;
	endproperty
	a_quiet: assert property (p_quiet) else $error("reset request while disabled");
endmodule : wwd_top_props
bind wwd_top wwd_top_props wwd_top_props_inst (.CORE_CLK, .RST, .OSC_MS_TICK, .ADDR, .WDATA, .WR, .RD,
	.RDATA, .WD_RESET_REQ);

/* File: tb/wwd_top_tb_top.sv */
// self-checking bench for the window watchdog registers
`timescale 1ns/1ps
module wwd_top_tb_top;
	logic        clk     = 1'b0;
	logic        rst     = 1'b1;
	logic        tick    = 1'b0;
	logic [15:0] addr    = 16'h0000;
	logic [15:0] wdata   = 16'h0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic [15:0] rdata;
	logic        req;
	int          err_count = 0;
	int          n_tests   = 0;
	int          req_cnt   = 0;
	always #25 clk = ~clk;
	wwd_top wwd_top_inst (.CORE_CLK(clk), .RST(rst), .OSC_MS_TICK(tick), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .WD_RESET_REQ(req));
	// count requests so both missing and extra ones show
	always @(posedge clk) begin
		if (req === 1'b1) begin
			req_cnt <= req_cnt + 1;
		end
	end
	// =========================================================
	// bus, tick and compare tasks
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t read %h expected %h", $time, got, exp);
		end
	endtask : chk16
	task automatic chk_req(input int exp);
		n_tests++;
		if (req_cnt != exp) begin
			err_count++;
			$display("[FAIL] %0t requests %0d expected %0d", $time, req_cnt, exp);
		end
	endtask : chk_req
	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk16(rdata, exp);
	endtask : bus_rd
	// n ms ticks, then a settling gap long enough for a request to be counted
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
		end
		repeat (4) @(posedge clk);
	endtask : ticks
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask : do_reset
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	// =========================================================
	// main sequence
	initial begin
		do_reset();
		bus_rd(16'h0E10, 16'h0084);
		bus_rd(16'h0E12, 16'h0001);
		bus_rd(16'h0E14, 16'h0000);
		bus_wr(16'h0E10, 16'h0083);
		bus_rd(16'h0E10, 16'h0084);
		bus_wr(16'h0E10, 16'h8000);
		bus_rd(16'h0F10, 16'h0004);
		for (int c = 1; c < 8; c++) begin
			bus_wr(16'h0E10, 16'h0100 | 16'(c));
			bus_rd(16'h0E10, 16'(c));
		end
		bus_rd(16'h0E16, 16'h0000);
		bus_rd(16'h0D10, 16'h0000);
		$display("test control done");
		// disabled: no expiry and rearm writes ignored
		do_reset();
		bus_wr(16'h0E10, 16'h0700);
		bus_rd(16'h0E12, 16'h0002);
		bus_wr(16'h0E14, 16'h0033);
		bus_rd(16'h0E14, 16'h0000);
		ticks(300);
		chk_req(0);
		// a later nonzero code turns the watchdog back on with the window shut
		bus_wr(16'h0E10, 16'h0101);
		bus_rd(16'h0E12, 16'h0000);
		$display("test off done");
		// initial phase: wrong first key, then expiry at 256 ms
		do_reset();
		bus_wr(16'h0E14, 16'h0055);
		ticks(0);
		chk_req(1);
		ticks(255);
		chk_req(1);
		ticks(1);
		chk_req(2);
		$display("test initial done");
		// window mode at 4 ms: closed half, open half, keys alternate
		bus_wr(16'h0E10, 16'h0701);
		bus_wr(16'h0E14, 16'h00AA);
		bus_rd(16'h0E12, 16'h0000);
		ticks(1);
		bus_rd(16'h0E12, 16'h0000);
		ticks(1);
		bus_rd(16'h0E12, 16'h0001);
		bus_wr(16'h0E14, 16'h0055);
		bus_rd(16'h0E12, 16'h0000);
		ticks(2);
		bus_wr(16'h0E14, 16'h00AA);
		ticks(0);
		chk_req(2);
		bus_wr(16'h0E14, 16'h0055);
		ticks(0);
		chk_req(3);
		bus_wr(16'h0E14, 16'h00AA);
		ticks(4);
		chk_req(4);
		// a key that is neither of the two while enabled
		bus_wr(16'h0E14, 16'h0012);
		ticks(0);
		chk_req(5);
		$display("test window done");
		summarize();
	end
	// hang guard: far beyond the longest sequence
	initial begin
		#(50 * 20000);
		err_count++;
		summarize();
	end
endmodule : wwd_top_tb_top
